/* File: verilog/can_phy_pkg.sv */
// Constants, register map and types for the CAN transceiver mode logic
package can_phy_pkg;
   // APB register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFF = 8'h0c;
   localparam logic [7:0] TX_LIMIT_OFF = 8'h10;
   localparam logic [7:0] RX_LIMIT_OFF = 8'h14;
   // Control field positions
   localparam int CTRL_QUIET_BIT = 0;
   localparam int CTRL_RXTO_EN_BIT = 1;
   localparam int CTRL_THERM_BIT = 2;
   localparam int CTRL_UVLO_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h2;
   // Event / status bit positions
   localparam int EV_TXTO = 0;
   localparam int EV_RXTO = 1;
   localparam int EV_FAULT = 2;
   localparam int EV_WIDTH = 3;
   // Dominant limits in clock cycles (20 MHz clock)
   localparam int LIMIT_W = 24;
   localparam logic [23:0] TX_LIMIT_RESET = 24'h004e20;
   localparam logic [23:0] RX_LIMIT_RESET = 24'h004e20;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   // Bus-state input encoding
   typedef enum logic [1:0] {
      BUS_RECESSIVE = 2'b00,
      BUS_DOMINANT = 2'b01,
      BUS_OPEN = 2'b10
   } bus_state_t;
   typedef enum logic [1:0] {
      DTO_IDLE = 2'b00,
      DTO_COUNT = 2'b01,
      DTO_EXPIRED = 2'b10
   } dto_state_t;
endpackage

/* File: verilog/dominant_timer.sv */
// Dominant timeout timer: starts on a dominant edge, expires past a limit
`timescale 1ns/1ps
module dominant_timer
   import can_phy_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic dominant_i,
   input wire logic [LIMIT_W-1:0] limit_i,
   output logic expired_o,
   output logic expire_pulse_o
);
   typedef struct packed {
      dto_state_t st;
      logic [LIMIT_W-1:0] cnt;
      logic pulse;
   } tstate_t;
   tstate_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.pulse = 1'b0;
      case (s_q.st)
         DTO_IDLE: begin
            s_d.cnt = '0;
            if (dominant_i) begin
               s_d.st = DTO_COUNT;
            end
         end
         DTO_COUNT: begin
            if (!dominant_i) begin
               s_d.st = DTO_IDLE;
            end else if (s_q.cnt >= limit_i) begin
               s_d.st = DTO_EXPIRED;
               s_d.pulse = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt + 1'b1;
            end
         end
         DTO_EXPIRED: begin
            // Only a return to recessive clears the timeout
            if (!dominant_i) begin
               s_d.st = DTO_IDLE;
            end
         end
         default: s_d.st = DTO_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '{st: DTO_IDLE, cnt: '0, pulse: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign expired_o = (s_q.st == DTO_EXPIRED);
   assign expire_pulse_o = s_q.pulse;
endmodule

/* File: verilog/can_transceiver_mode_logic.sv */
// Logic side of a CAN transceiver: modes, dominant timeouts, fault pin
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module can_transceiver_mode_logic
   import can_phy_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_data_i,
   input wire logic tx_data_float_i,
   input wire logic quiet_i,
   input wire logic quiet_float_i,
   input wire logic [1:0] bus_state_i,
   output logic drive_dominant_o,
   output logic rx_data_o,
   output logic fault_out_o,
   output logic fault_oe_o,
   output logic irq_o
);
   typedef struct packed {
      logic [3:0] ctrl;
      logic [EV_WIDTH-1:0] irq_stat;
      logic [EV_WIDTH-1:0] irq_mask;
      logic [LIMIT_W-1:0] tx_limit;
      logic [LIMIT_W-1:0] rx_limit;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic drive;
      logic rx;
      logic fault_oe;
      logic fault_prev;
      logic irq;
   } state_t;
   state_t s_q, s_d;

   logic tx_eff;
   logic quiet_eff;
   logic bus_dom;
   logic tx_expired, tx_pulse;
   logic rx_expired, rx_pulse;
   logic fault_now;
   logic acc;

   function automatic logic [31:0] pad_word(input logic [LIMIT_W-1:0] v);
      pad_word = ZERO_WORD;
      pad_word[LIMIT_W-1:0] = v;
   endfunction

   // Floating pins resolve to their internal bias levels
   assign tx_eff = tx_data_float_i ? 1'b1 : tx_data_i;
   assign quiet_eff = quiet_float_i ? 1'b0 : quiet_i;
   // Open and recessive are both non-dominant
   assign bus_dom = (bus_state_t'(bus_state_i) == BUS_DOMINANT);

   // Tx timer runs on the transmit level; fall starts it, rise clears it
   dominant_timer u_tx_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .dominant_i(!tx_eff),
      .limit_i(s_q.tx_limit),
      .expired_o(tx_expired),
      .expire_pulse_o(tx_pulse)
   );

   // Receive timer follows the bus; dominant bus is a fall of receive
   logic rx_timer_exp, rx_timer_pulse;
   dominant_timer u_rx_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .dominant_i(bus_dom),
      .limit_i(s_q.rx_limit),
      .expired_o(rx_timer_exp),
      .expire_pulse_o(rx_timer_pulse)
   );
   assign rx_expired = rx_timer_exp & s_q.ctrl[CTRL_RXTO_EN_BIT];
   assign rx_pulse = rx_timer_pulse & s_q.ctrl[CTRL_RXTO_EN_BIT];

   assign fault_now = tx_expired | rx_expired
      | s_q.ctrl[CTRL_THERM_BIT] | s_q.ctrl[CTRL_UVLO_BIT];
   assign acc = psel & penable;

   always_comb begin
      logic quiet;
      logic [EV_WIDTH-1:0] ev;
      quiet = quiet_eff | s_q.ctrl[CTRL_QUIET_BIT];
      ev = '0;
      s_d = s_q;
      // Driver on only in normal mode, with low transmit, no fault block
      s_d.drive = !quiet && !tx_eff && !tx_expired
         && !s_q.ctrl[CTRL_THERM_BIT] && !s_q.ctrl[CTRL_UVLO_BIT];
      // Receive mirrors the bus in every mode unless timed out
      s_d.rx = !(bus_dom && !rx_expired);
      // Open drain: enable pulls low while healthy
      s_d.fault_oe = !fault_now;
      s_d.fault_prev = fault_now;
      ev[EV_TXTO] = tx_pulse;
      ev[EV_RXTO] = rx_pulse;
      ev[EV_FAULT] = fault_now & !s_q.fault_prev;

      // APB slave, one wait state (pready is registered)
      s_d.ready = acc && !s_q.ready;
      s_d.err = 1'b0;
      s_d.rdata = ZERO_WORD;
      if (psel && penable && !s_q.ready) begin
         if (paddr == CTRL_OFF) begin
            s_d.rdata[3:0] = s_q.ctrl;
            if (pwrite) begin
               s_d.ctrl = pwdata[3:0];
            end
         end else if (paddr == STATUS_OFF) begin
            s_d.rdata[EV_TXTO] = tx_expired;
            s_d.rdata[EV_RXTO] = rx_expired;
            s_d.rdata[EV_FAULT] = fault_now;
            s_d.rdata[EV_WIDTH] = bus_dom;
         end else if (paddr == IRQ_STAT_OFF) begin
            s_d.rdata[EV_WIDTH-1:0] = s_q.irq_stat;
            if (pwrite) begin
               s_d.irq_stat = s_q.irq_stat & ~pwdata[EV_WIDTH-1:0];
            end
         end else if (paddr == IRQ_MASK_OFF) begin
            s_d.rdata[EV_WIDTH-1:0] = s_q.irq_mask;
            if (pwrite) begin
               s_d.irq_mask = pwdata[EV_WIDTH-1:0];
            end
         end else if (paddr == TX_LIMIT_OFF) begin
            s_d.rdata = pad_word(s_q.tx_limit);
            if (pwrite) begin
               s_d.tx_limit = pwdata[LIMIT_W-1:0];
            end
         end else if (paddr == RX_LIMIT_OFF) begin
            s_d.rdata = pad_word(s_q.rx_limit);
            if (pwrite) begin
               s_d.rx_limit = pwdata[LIMIT_W-1:0];
            end
         end else begin
            s_d.err = 1'b1;
         end
      end
      // New events win over a write-one clear in the same cycle
      s_d.irq_stat = s_d.irq_stat | ev;
      s_d.irq = |(s_d.irq_stat & s_q.irq_mask);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '{ctrl: CTRL_RESET, irq_stat: '0, irq_mask: '0,
                  tx_limit: TX_LIMIT_RESET, rx_limit: RX_LIMIT_RESET,
                  rdata: ZERO_WORD, ready: 1'b0, err: 1'b0,
                  drive: 1'b0, rx: 1'b1, fault_oe: 1'b1,
                  fault_prev: 1'b0, irq: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = s_q.err;
   assign drive_dominant_o = s_q.drive;
   assign rx_data_o = s_q.rx;
   assign fault_out_o = 1'b0;
   assign fault_oe_o = s_q.fault_oe;
   assign irq_o = s_q.irq;

   // Mode and driver checks; outputs lag their cause by one edge
   sequence quiet_sel;
      quiet_eff || s_q.ctrl[CTRL_QUIET_BIT];
   endsequence

   silent_no_drive_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      quiet_sel |=> !drive_dominant_o)
      else $error("driver active in silent mode");

   normal_drive_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !quiet_eff && !s_q.ctrl[CTRL_QUIET_BIT] && !tx_eff && !tx_expired
      && !s_q.ctrl[CTRL_THERM_BIT] && !s_q.ctrl[CTRL_UVLO_BIT]
      |=> drive_dominant_o)
      else $error("normal mode low transmit did not drive");

   tx_high_idle_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      tx_eff |=> !drive_dominant_o)
      else $error("transmit high drove the bus");

   float_tx_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      tx_data_float_i |=> !drive_dominant_o)
      else $error("floating transmit drove the bus");

   float_quiet_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      quiet_float_i && !s_q.ctrl[CTRL_QUIET_BIT] && !tx_data_float_i
      && !tx_data_i && !tx_expired && !s_q.ctrl[CTRL_THERM_BIT]
      && !s_q.ctrl[CTRL_UVLO_BIT] |=> drive_dominant_o)
      else $error("floating quiet not taken as normal");

   therm_block_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_q.ctrl[CTRL_THERM_BIT] |=> !drive_dominant_o)
      else $error("driver on during thermal stop");

   uv_block_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_q.ctrl[CTRL_UVLO_BIT] |=> !drive_dominant_o)
      else $error("driver on during undervoltage");

   // Receive path checks
   rx_mirror_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !bus_dom |=> rx_data_o)
      else $error("receive low on non-dominant bus");

   rx_low_dom_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      bus_dom && !rx_expired |=> !rx_data_o)
      else $error("receive not low on dominant bus");

   silent_rx_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      quiet_sel ##0 (bus_dom && !rx_expired) |=> !rx_data_o)
      else $error("receive not mirroring bus in silent mode");

   open_bus_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      bus_state_i == BUS_OPEN |=> rx_data_o)
      else $error("open bus not read as high");

   sequence rx_dom_held;
      bus_dom && !rx_expired ##1 bus_dom;
   endsequence

   rx_timeout_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rx_expired |=> rx_data_o)
      else $error("receive held low after timeout");

   rxto_off_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !s_q.ctrl[CTRL_RXTO_EN_BIT] |-> !rx_expired)
      else $error("rx timeout active while disabled");

   rx_clear_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rx_dom_held ##1 !bus_dom |=> ##1 !rx_timer_exp)
      else $error("rx timeout not cleared by recessive bus");

   rx_start_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(bus_dom) |=> !rx_timer_exp)
      else $error("rx timer expired at dominant start");

   rx_event_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rx_pulse |-> rx_expired)
      else $error("rx timeout event without timeout");

   // Fault pin checks
   fault_pin_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      fault_now |=> !fault_oe_o)
      else $error("fault pin still pulling low");

   fault_release_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !fault_now |=> fault_oe_o)
      else $error("fault pin released with no fault");

   fault_low_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      fault_oe_o |-> !fault_out_o)
      else $error("fault pin driven high");

   fault_src_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_q.ctrl[CTRL_THERM_BIT] || s_q.ctrl[CTRL_UVLO_BIT] |-> fault_now)
      else $error("fault missing for thermal or undervoltage");

   tx_fault_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      tx_expired |-> fault_now)
      else $error("fault missing for tx timeout");

   rx_fault_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rx_expired |-> fault_now)
      else $error("fault missing for rx timeout");

   // Transmit timeout checks
   tx_disable_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      tx_expired |=> !drive_dominant_o)
      else $error("driver on after tx timeout");

   tx_start_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $fell(tx_eff) |=> !tx_expired)
      else $error("tx timer expired at transmit fall");

   tx_restore_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      tx_expired && tx_eff |=> !tx_expired)
      else $error("tx timeout not cleared by transmit high");

   tx_event_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      tx_pulse |-> tx_expired)
      else $error("tx timeout event without timeout");

   // Limits and register bus
   tx_limit_wr_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      acc && !pready && pwrite && paddr == TX_LIMIT_OFF
      |=> s_q.tx_limit == $past(pwdata[LIMIT_W-1:0]))
      else $error("tx limit write lost");

   rx_limit_wr_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      acc && !pready && pwrite && paddr == RX_LIMIT_OFF
      |=> s_q.rx_limit == $past(pwdata[LIMIT_W-1:0]))
      else $error("rx limit write lost");

   irq_level_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $stable(s_q.irq_mask) |-> irq_o == |(s_q.irq_stat & s_q.irq_mask))
      else $error("interrupt level does not match status");

   pready_pulse_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      pready |=> !pready)
      else $error("ready held longer than one cycle");

   pslverr_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      pslverr |-> pready)
      else $error("error response without ready");
endmodule

/* File: verif/can_host_model.sv */
// Host link-layer controller model: transmit level, quiet select, fault pin
`timescale 1ns/1ps
module can_host_model (
   input wire logic clk_i,
   input wire logic fault_out_i,
   input wire logic fault_oe_i,
   output logic tx_data_o,
   output logic tx_float_o,
   output logic quiet_o,
   output logic quiet_float_o,
   output logic fault_seen_o
);
   // Idle is recessive in normal mode, so nothing is driven before reset ends
   initial begin
      tx_data_o = 1'b1;
      tx_float_o = 1'b0;
      quiet_o = 1'b0;
      quiet_float_o = 1'b0;
   end
   // A released fault pin reads high through the board pull-up
   assign fault_seen_o = fault_oe_i ? fault_out_i : 1'b1;
   // Pins change just after an edge and then hold, as a real controller does
   task automatic set_pins(input logic tx, input logic txf, input logic q,
                           input logic qf);
      @(posedge clk_i);
      tx_data_o <= tx;
      tx_float_o <= txf;
      quiet_o <= q;
      quiet_float_o <= qf;
   endtask
endmodule

/* File: verif/test_can_transceiver_mode_logic.sv */
// Self-checking bench for the CAN transceiver mode logic
`timescale 1ns/1ps
module test_can_transceiver_mode_logic;
   import can_phy_pkg::*;
   logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic tx_data_i, tx_data_float_i, quiet_i, quiet_float_i;
   logic [1:0] bus_state_i;
   logic drive_dominant_o, rx_data_o, fault_out_o, fault_oe_o, irq_o;
   logic fault_seen;
   int errors, total_checks;
   can_transceiver_mode_logic can_transceiver_mode_logic_inst (.clk_i(clk_i),
      .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_data_i(tx_data_i),
      .tx_data_float_i(tx_data_float_i), .quiet_i(quiet_i),
      .quiet_float_i(quiet_float_i), .bus_state_i(bus_state_i),
      .drive_dominant_o(drive_dominant_o), .rx_data_o(rx_data_o),
      .fault_out_o(fault_out_o), .fault_oe_o(fault_oe_o), .irq_o(irq_o));
   can_host_model can_host_model_inst (.clk_i(clk_i),
      .fault_out_i(fault_out_o), .fault_oe_i(fault_oe_o),
      .tx_data_o(tx_data_i), .tx_float_o(tx_data_float_i),
      .quiet_o(quiet_i), .quiet_float_o(quiet_float_i),
      .fault_seen_o(fault_seen));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // One APB transfer; the request holds until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk("pready", 1, 0);
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic bus(input bus_state_t v);
      @(posedge clk_i);
      bus_state_i <= v;
   endtask
   task automatic pins(input logic tx, input logic txf, input logic q,
                       input logic qf);
      can_host_model_inst.set_pins(tx, txf, q, qf);
      tick(2);
   endtask
   logic [7:0] offs [5];
   logic [31:0] exps [5];
   initial begin
      errors = 0;
      total_checks = 0;
      rst_i = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = ZERO_WORD;
      bus_state_i = BUS_RECESSIVE;
      offs = '{CTRL_OFF, STATUS_OFF, IRQ_MASK_OFF, TX_LIMIT_OFF, RX_LIMIT_OFF};
      exps = '{{28'h0, CTRL_RESET}, ZERO_WORD, ZERO_WORD,
               {8'h00, TX_LIMIT_RESET}, {8'h00, RX_LIMIT_RESET}};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      tick(1);
      chk("rx_reset", 1, rx_data_o);
      chk("fault_reset", 0, fault_seen);
      apb(1'b1, STATUS_OFF, 32'hffff_ffff);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, offs[i], ZERO_WORD);
         chk("reg_reset", exps[i], rd);
         chk("read_err", 0, err);
      end
      apb(1'b0, 8'h20, ZERO_WORD);
      chk("unmapped_err", 1, err);
      chk("unmapped_data", 0, rd);
      apb(1'b1, TX_LIMIT_OFF, 32'h8);
      apb(1'b1, RX_LIMIT_OFF, 32'h8);
      apb(1'b0, RX_LIMIT_OFF, ZERO_WORD);
      chk("rx_limit", 32'h8, rd);
      $display("Test registers done");
      pins(1'b0, 1'b0, 1'b0, 1'b0);
      chk("drive_normal", 1, drive_dominant_o);
      pins(1'b1, 1'b0, 1'b0, 1'b0);
      chk("drive_high", 0, drive_dominant_o);
      pins(1'b0, 1'b1, 1'b0, 1'b0);
      chk("drive_txfloat", 0, drive_dominant_o);
      pins(1'b0, 1'b0, 1'b1, 1'b1);
      chk("drive_qfloat", 1, drive_dominant_o);
      pins(1'b0, 1'b0, 1'b1, 1'b0);
      chk("drive_silent", 0, drive_dominant_o);
      pins(1'b1, 1'b0, 1'b0, 1'b0);
      apb(1'b1, CTRL_OFF, 32'h3);
      pins(1'b0, 1'b0, 1'b0, 1'b0);
      chk("drive_swquiet", 0, drive_dominant_o);
      pins(1'b1, 1'b0, 1'b0, 1'b0);
      apb(1'b1, CTRL_OFF, 32'h2);
      // Short dominant spells stay well under the timeout limit
      for (int q = 0; q < 2; q++) begin
         for (int b = 0; b < 3; b++) begin
            pins(1'b1, 1'b0, q[0], 1'b0);
            bus(bus_state_t'(b[1:0]));
            tick(2);
            chk("rx_follow", (b == 1) ? 0 : 1, rx_data_o);
         end
      end
      bus(BUS_RECESSIVE);
      pins(1'b1, 1'b0, 1'b0, 1'b0);
      $display("Test modes done");
      apb(1'b1, IRQ_MASK_OFF, 32'h7);
      pins(1'b0, 1'b0, 1'b0, 1'b0);
      tick(4);
      chk("drive_early", 1, drive_dominant_o);
      tick(8);
      chk("drive_timeout", 0, drive_dominant_o);
      chk("fault_tx", 1, fault_seen);
      chk("irq_tx", 1, irq_o);
      apb(1'b0, STATUS_OFF, ZERO_WORD);
      chk("status_tx", 1, rd[EV_TXTO]);
      pins(1'b1, 1'b0, 1'b0, 1'b0);
      tick(1);
      chk("fault_tx_clear", 0, fault_seen);
      apb(1'b1, IRQ_STAT_OFF, 32'h7);
      tick(2);
      chk("irq_clear", 0, irq_o);
      $display("Test transmit timeout done");
      bus(BUS_DOMINANT);
      tick(4);
      chk("rx_dom", 0, rx_data_o);
      apb(1'b0, STATUS_OFF, ZERO_WORD);
      chk("status_bus", 1, rd[EV_WIDTH]);
      tick(10);
      chk("rx_timeout", 1, rx_data_o);
      chk("fault_rx", 1, fault_seen);
      bus(BUS_RECESSIVE);
      tick(3);
      chk("fault_rx_clear", 0, fault_seen);
      bus(BUS_DOMINANT);
      tick(2);
      chk("rx_again", 0, rx_data_o);
      bus(BUS_RECESSIVE);
      apb(1'b1, IRQ_STAT_OFF, 32'h7);
      $display("Test receive timeout done");
      apb(1'b1, IRQ_MASK_OFF, ZERO_WORD);
      apb(1'b1, CTRL_OFF, 32'h6);
      tick(3);
      chk("fault_therm", 1, fault_seen);
      chk("irq_masked", 0, irq_o);
      apb(1'b0, IRQ_STAT_OFF, ZERO_WORD);
      chk("stat_fault", 1, rd[EV_FAULT]);
      apb(1'b1, IRQ_MASK_OFF, 32'h4);
      apb(1'b1, CTRL_OFF, 32'ha);
      tick(3);
      chk("irq_unmasked", 1, irq_o);
      chk("fault_uv", 1, fault_seen);
      apb(1'b1, CTRL_OFF, 32'h2);
      tick(3);
      chk("fault_none", 0, fault_seen);
      apb(1'b1, IRQ_STAT_OFF, 32'h7);
      tick(2);
      chk("irq_end", 0, irq_o);
      $display("Test fault sources done");
      tally_and_finish();
   end
endmodule
